/* File: hw/btrp_pkg.sv */
// Constants shared by the bus target region permission block.
package btrp_pkg;
	localparam int          NUM_TARGETS   = 14;
	localparam int          NUM_REGIONS   = 9;
	localparam int          ADR_W         = 12;
	localparam int          TGT_LSB       = 8;
	localparam int          RGN_LSB       = 4;
	localparam int          KIND_LSB      = 2;
	localparam logic [1:0]  KIND_DESC     = 2'h0;
	localparam logic [1:0]  KIND_GRANT    = 2'h1;
	localparam int          BASE_W        = 22;
	localparam int          BASE_LSB      = 10;
	localparam int          PRI_BIT       = 9;
	localparam int          SIZE_W        = 5;
	localparam int          SIZE_LSB      = 3;
	localparam int          GRANT_W       = 4;
	localparam int          DESC_W        = BASE_W + 1 + SIZE_W;
	localparam int          EXT_W         = 41;
	localparam logic [EXT_W-1:0] EXT_UNIT = 41'h00000000400;
	localparam logic [DESC_W-1:0]  DESC_RST  = 28'h0000000;
	localparam logic [GRANT_W-1:0] GRANT_RST = 4'h7;
endpackage : btrp_pkg

/* File: hw/btrp_region_match.sv */
// Address match of one region against its base and size code.
`timescale 1ns/100ps
`default_nettype none
module btrp_region_match
	import btrp_pkg::*;
(
	// Region fields
	input  wire logic [BASE_W-1:0] base,
	input  wire logic [SIZE_W-1:0] size,
	// Address under test
	input  wire logic [31:0]       addr,
	// Result
	output logic                   hit
);
	logic [EXT_W-1:0] start;
	logic [EXT_W-1:0] extent;
	logic [EXT_W-1:0] offset;

	always_comb begin
		start  = {9'h000, base, 10'h000};
		extent = EXT_UNIT << (size - 5'h01);
		offset = {9'h000, addr} - start;
		hit = (size != 5'h00) && ({9'h000, addr} >= start) && (offset < extent);
	end
endmodule : btrp_region_match
`default_nettype wire

/* File: hw/btrp_top.sv */
// Region descriptors, write grants, Wishbone slave and write permission check.
//
// Overview of operation
// - Descriptor and grants per target and region.
// - Region base in bits 31 to 10.
// - Bit 9 chooses level two priority.
// - Size code gives power-of-two kilobyte extent.
// - Zero size code means region absent.
// - Grant bit one lets group write.
// - Grant bit zero denies group write.
// - Unused register bits read as zero.
// - Region 0 of some targets holds fixed read-only presets.
`timescale 1ns/100ps
`default_nettype none
module btrp_top
	import btrp_pkg::*;
#(
	parameter int                      NT            = NUM_TARGETS,
	parameter int                      NR            = NUM_REGIONS,
	parameter logic [NUM_TARGETS-1:0]  FIXED_TARGETS = 14'h0000,
	parameter logic [DESC_W-1:0]       FIXED_DESC    = DESC_RST,
	parameter logic [GRANT_W-1:0]      FIXED_GRANT   = GRANT_RST
)(
	// Clock, reset, enable
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic                  wb_ack_o,
	output logic      [31:0]      wb_dat_o,
	// Access check from an initiator
	input  wire logic             chk_valid,
	input  wire logic [31:0]      chk_addr,
	input  wire logic             chk_write,
	input  wire logic [1:0]       chk_group,
	input  wire logic [3:0]       chk_target,
	output logic                  chk_done,
	output logic                  chk_allow
);
	typedef struct packed {
		logic [NT-1:0][NR-1:0][DESC_W-1:0]  desc;
		logic [NT-1:0][NR-1:0][GRANT_W-1:0] grant;
		logic                               ack;
		logic [31:0]                        dat;
		logic                               done;
		logic                               allow;
	} btrp_state_s;

	typedef struct packed {
		logic       ok;
		logic [3:0] tgt;
		logic [3:0] rgn;
		logic       is_grant;
	} btrp_dec_s;

	btrp_state_s state_reg;
	btrp_state_s state_next;

	function automatic btrp_dec_s btrp_decode(input logic [ADR_W-1:0] a);
		btrp_dec_s d;
		d.tgt      = a[TGT_LSB +: 4];
		d.rgn      = a[RGN_LSB +: 4];
		d.is_grant = (a[KIND_LSB +: 2] == KIND_GRANT);
		d.ok       = (int'(d.tgt) < NT) && (int'(d.rgn) < NR)
			&& ((a[KIND_LSB +: 2] == KIND_DESC) || d.is_grant);
		return d;
	endfunction : btrp_decode

	function automatic logic [31:0] btrp_desc_word(input logic [DESC_W-1:0] v);
		return {v[DESC_W-1 -: BASE_W], v[SIZE_W], 1'b0, v[SIZE_W-1:0], 3'h0};
	endfunction : btrp_desc_word

	function automatic logic [31:0] btrp_merge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[8*b +: 8] = wr[8*b +: 8];
			end
		end
		return m;
	endfunction : btrp_merge

	btrp_dec_s            dec;
	logic                 req;
	logic [31:0]          cur_word;
	logic [31:0]          new_word;
	logic                 fixed_hit;
	logic [NR-1:0]        rgn_hit;
	logic [NR-1:0][DESC_W-1:0]  sel_desc;
	logic [NR-1:0][GRANT_W-1:0] sel_grant;
	logic                 tgt_ok;
	logic                 hit_hi;
	logic                 hit_lo;
	logic                 perm_hi;
	logic                 perm_lo;
	logic                 verdict;

	always_comb begin
		tgt_ok = int'(chk_target) < NT;
		for (int r = 0; r < NR; r++) begin
			sel_desc[r]  = tgt_ok ? state_reg.desc[chk_target][r] : DESC_RST;
			sel_grant[r] = tgt_ok ? state_reg.grant[chk_target][r] : GRANT_RST;
		end
	end

	generate
		for (genvar g = 0; g < NR; g++) begin : g_match
			btrp_region_match u_match (
				.base (sel_desc[g][DESC_W-1 -: BASE_W]),
				.size (sel_desc[g][SIZE_W-1:0]),
				.addr (chk_addr),
				.hit  (rgn_hit[g])
			);
		end
	endgenerate

	always_comb begin
		hit_hi  = 1'b0;
		hit_lo  = 1'b0;
		perm_hi = 1'b1;
		perm_lo = 1'b1;
		// Lowest region index wins within one priority level.
		for (int r = NR - 1; r >= 0; r--) begin
			if (rgn_hit[r]) begin
				if (sel_desc[r][SIZE_W]) begin
					hit_hi  = 1'b1;
					perm_hi = sel_grant[r][chk_group];
				end else begin
					hit_lo  = 1'b1;
					perm_lo = sel_grant[r][chk_group];
				end
			end
		end
		if (!chk_write) begin
			verdict = 1'b1;
		end else if (hit_hi) begin
			verdict = perm_hi;
		end else if (hit_lo) begin
			verdict = perm_lo;
		end else begin
			verdict = 1'b1;
		end
	end

	always_comb begin
		state_next = state_reg;
		dec        = btrp_decode(wb_adr_i);
		req        = wb_cyc_i && wb_stb_i && !state_reg.ack;
		fixed_hit  = dec.ok && FIXED_TARGETS[dec.tgt] && (dec.rgn == 4'h0);
		cur_word   = 32'h00000000;
		if (dec.ok) begin
			cur_word = dec.is_grant
				? {28'h0000000, state_reg.grant[dec.tgt][dec.rgn]}
				: btrp_desc_word(state_reg.desc[dec.tgt][dec.rgn]);
		end
		new_word = btrp_merge(cur_word, wb_dat_i, wb_sel_i);
		state_next.ack = req;
		if (req) begin
			state_next.dat = cur_word;
		end
		if (req && wb_we_i && dec.ok && !fixed_hit) begin
			if (dec.is_grant) begin
				state_next.grant[dec.tgt][dec.rgn] = new_word[GRANT_W-1:0];
			end else begin
				state_next.desc[dec.tgt][dec.rgn] = {new_word[31:BASE_LSB],
					new_word[PRI_BIT], new_word[SIZE_LSB +: SIZE_W]};
			end
		end
		state_next.done = chk_valid;
		if (chk_valid) begin
			state_next.allow = verdict;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int t = 0; t < NT; t++) begin
				for (int r = 0; r < NR; r++) begin
					if (FIXED_TARGETS[t] && r == 0) begin
						state_reg.desc[t][r]  <= FIXED_DESC;
						state_reg.grant[t][r] <= FIXED_GRANT;
					end else begin
						state_reg.desc[t][r]  <= DESC_RST;
						state_reg.grant[t][r] <= GRANT_RST;
					end
				end
			end
			state_reg.ack   <= 1'b0;
			state_reg.dat   <= 32'h00000000;
			state_reg.done  <= 1'b0;
			state_reg.allow <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign wb_ack_o  = state_reg.ack;
	assign wb_dat_o  = state_reg.dat;
	assign chk_done  = state_reg.done;
	assign chk_allow = state_reg.allow;
endmodule : btrp_top
`default_nettype wire

/* File: dv/btrp_top_asserts.sv */
// Port checker for the region permission block.
`timescale 1ns/100ps
`default_nettype none
module btrp_top_asserts (
	// Clock and control
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	// Wishbone slave
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Access check
	input wire logic        chk_valid,
	input wire logic        chk_write,
	input wire logic        chk_done,
	input wire logic        chk_allow
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ACK_PULSE: assert property (ce && wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_TAKE: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_DESC_PAD: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h0
		|-> wb_dat_o[8] == 1'b0 && wb_dat_o[2:0] == 3'h0) else $error("descriptor pad set");
	AST_GRANT_PAD: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h1
		|-> wb_dat_o[31:4] == 28'h0) else $error("grant pad set");
	AST_DONE: assert property (ce && chk_valid |=> chk_done)
		else $error("check not answered");
	AST_READ_OK: assert property (ce && chk_valid && !chk_write |=> chk_allow)
		else $error("read blocked");
	AST_HOLD: assert property (!chk_done |-> $stable(chk_allow))
		else $error("verdict moved without done");
	cover property (chk_done && !chk_allow);
	cover property (chk_done && chk_allow);
	cover property (wb_ack_o && wb_we_i);
endmodule : btrp_top_asserts
bind btrp_top btrp_top_asserts u_btrp_top_asserts (.*);
`default_nettype wire

/* File: dv/btrp_init.sv */
// Bus initiator model that presents access checks.
`timescale 1ns/100ps
`default_nettype none
module btrp_init (
	// Clock
	input  wire logic        clk,
	// Check port
	input  wire logic        chk_done,
	input  wire logic        chk_allow,
	output logic             chk_valid,
	output logic      [31:0] chk_addr,
	output logic             chk_write,
	output logic      [1:0]  chk_group,
	output logic      [3:0]  chk_target
);
	initial {chk_valid, chk_addr, chk_write, chk_group, chk_target} = '0;
	task automatic chk(input logic [31:0] a, input logic w, input logic [1:0] g,
		input logic [3:0] t, output logic ok);
		@(posedge clk);
		chk_valid  <= 1'b1;
		chk_addr   <= a;
		chk_write  <= w;
		chk_group  <= g;
		chk_target <= t;
		@(posedge clk);
		chk_valid <= 1'b0;
		// Released address toggles so a stale value is never trusted.
		chk_addr  <= ~a;
		do @(posedge clk); while (chk_done !== 1'b1);
		ok = chk_allow;
	endtask : chk
endmodule : btrp_init
`default_nettype wire

/* File: dv/btrp_top_tb.sv */
// Self-checking bench for the region permission block.
`timescale 1ns/100ps
`default_nettype none
module btrp_top_tb;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, ok;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        chk_valid, chk_write, chk_done, chk_allow;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i = 4'hF, chk_target;
	logic [31:0] wb_dat_i, wb_dat_o, chk_addr;
	logic [1:0]  chk_group;
	int          errors, checks, cycles;
	always #20 clk = ~clk;
	btrp_top #(.FIXED_TARGETS(14'h2000)) u_btrp_top (.*);
	btrp_init u_btrp_init (.*);
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic cmp_reg(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		checks++;
		if (wb_dat_o !== e) begin
			errors++;
			$display("FAIL reg %h exp %h got %h", a, e, wb_dat_o);
		end
	endtask : cmp_reg
	task automatic cmp_ok(input logic [31:0] a, input logic w, input logic [1:0] g,
		input logic e);
		u_btrp_init.chk(a, w, g, 4'h2, ok);
		checks++;
		if (ok !== e) begin
			errors++;
			$display("FAIL allow %h group %0d exp %b got %b", a, g, e, ok);
		end
	endtask : cmp_ok
	task automatic test_done;
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cmp_reg(12'h000, 32'h0);
		cmp_reg(12'h004, 32'h7);
		wb(1'b1, 12'h210, 32'hFFFFFFFF);
		cmp_reg(12'h210, 32'hFFFFFEF8);
		wb(1'b1, 12'h214, 32'hFFFFFFF5);
		cmp_reg(12'h214, 32'h5);
		wb(1'b1, 12'hD04, 32'h0);
		cmp_reg(12'hD04, 32'h7);
		wb(1'b1, 12'hE00, 32'hFFFFFFFF);
		cmp_reg(12'hE00, 32'h0);
		wb(1'b1, 12'h210, 32'h4008);
		for (int g = 0; g < 4; g++)
			cmp_ok(32'h4000, 1'b1, 2'(g), 1'(4'h5 >> g));
		cmp_ok(32'h4400, 1'b1, 2'h1, 1'b1);
		cmp_ok(32'h4000, 1'b0, 2'h1, 1'b1);
		wb(1'b1, 12'h210, 32'h4018);
		cmp_ok(32'h4FFC, 1'b1, 2'h1, 1'b0);
		cmp_ok(32'h5000, 1'b1, 2'h1, 1'b1);
		wb(1'b1, 12'h220, 32'h4208);
		wb(1'b1, 12'h224, 32'h2);
		cmp_ok(32'h4000, 1'b1, 2'h1, 1'b1);
		cmp_ok(32'h4000, 1'b1, 2'h0, 1'b0);
		wb(1'b1, 12'h220, 32'h4200);
		cmp_ok(32'h4000, 1'b1, 2'h1, 1'b0);
		wb(1'b1, 12'h210, 32'h4000);
		cmp_ok(32'h4000, 1'b1, 2'h1, 1'b1);
		// Only lane 1 is written, so base low bits and priority change alone.
		wb_sel_i <= 4'h2;
		wb(1'b1, 12'h210, 32'hFFFFFFFF);
		wb_sel_i <= 4'hF;
		cmp_reg(12'h210, 32'h0000FE00);
		// A second reset in mid-run must bring back the values after reset.
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cmp_reg(12'h210, 32'h0);
		cmp_reg(12'h214, 32'h7);
		cmp_reg(12'hD04, 32'h7);
		cmp_ok(32'h4000, 1'b1, 2'h3, 1'b1);
		test_done();
	end
endmodule : btrp_top_tb
`default_nettype wire
